// File: vic_pkg.sv
package vic_pkg;
  // Register file addresses of the status registers
  localparam logic [5:0] ADDR_SECONDARY_IRQ_STATUS = 6'h0e;
  localparam logic [5:0] ADDR_PRIMARY_IRQ_STATUS = 6'h0f;
  // I/O control addresses of the mask registers
  localparam logic [5:0] IOC_SECONDARY_IRQ_MASK = 6'h0e;
  localparam logic [5:0] IOC_PRIMARY_IRQ_MASK = 6'h0f;

  // Primary status field positions
  localparam int BIT_MAIN_TIMER = 0;
  localparam int BIT_INPUT_CHANGE = 1;
  localparam int BIT_EXTERNAL = 2;
  localparam int BIT_AUX_A = 3;
  localparam int BIT_AUX_B = 4;
  localparam int BIT_AUX_C = 5;
  localparam int BIT_HIGH_PULSE = 6;
  localparam int BIT_LOW_PULSE = 7;
  // Secondary status field positions
  localparam int BIT_INPUT_CHANGE_WAKE = 1;
  localparam int BIT_COMPARATOR_WAKE = 2;
  localparam int BIT_CONV_WAKE = 3;
  localparam int BIT_COMPARATOR = 4;
  localparam int BIT_CONV_DONE = 5;
  localparam logic [7:0] SECONDARY_RW_MASK = 8'h3e;

  // Reset values
  localparam logic [7:0] PRIMARY_STATUS_RST = 8'h00;
  localparam logic [7:0] SECONDARY_STATUS_RST = 8'h00;
  localparam logic [7:0] PRIMARY_MASK_RST = 8'h00;
  localparam logic [7:0] SECONDARY_MASK_RST = 8'h00;

  // Noise rejection length in system clocks
  localparam int EXT_FILTER_CYCLES = 8;

  // Vector addresses
  localparam logic [9:0] VEC_EXTERNAL = 10'h003;
  localparam logic [9:0] VEC_INPUT_CHANGE = 10'h006;
  localparam logic [9:0] VEC_MAIN_TIMER = 10'h009;
  localparam logic [9:0] VEC_CONV_DONE = 10'h00c;
  localparam logic [9:0] VEC_COMPARATOR = 10'h00f;
  localparam logic [9:0] VEC_HIGH_PULSE = 10'h012;
  localparam logic [9:0] VEC_LOW_PULSE = 10'h015;
  localparam logic [9:0] VEC_AUX_A = 10'h018;
  localparam logic [9:0] VEC_AUX_B = 10'h01b;
  localparam logic [9:0] VEC_AUX_C = 10'h01e;
endpackage

// File: vic_top.sv
`timescale 1ns/1ps
module vic_top
  import vic_pkg::*;
#(
  parameter int FILTER_CYCLES = EXT_FILTER_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Same-clock event pulses
  input wire logic main_timer_ovf_i,
  input wire logic aux_timer_a_ovf_i,
  input wire logic aux_timer_b_ovf_i,
  input wire logic aux_timer_c_ovf_i,
  input wire logic high_pulse_underflow_i,
  input wire logic low_pulse_underflow_i,
  input wire logic conv_done_i,
  input wire logic comparator_change_i,
  // Pins
  input wire logic [7:0] port5_pins_i,
  input wire logic ext_pin_i,
  // Configuration
  input wire logic ext_edge_select_i,
  input wire logic low_freq_crystal_mode_i,
  // Core register access
  input wire logic [5:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic ioc_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic port5_read_i,
  // Instructions
  input wire logic global_irq_on_instr_i,
  input wire logic global_irq_off_instr_i,
  input wire logic return_from_irq_instr_i,
  input wire logic sleep_instr_i,
  // Vector handshake
  output logic irq_req_o,
  output logic [9:0] irq_vector_o,
  input wire logic irq_ack_i,
  output logic global_irq_en_o,
  output logic sleeping_o,
  output logic wake_o,
  // Context save and restore
  input wire logic [7:0] accumulator_i,
  input wire logic [7:0] core_status_reg_i,
  input wire logic [7:0] indirect_select_reg_i,
  output logic [7:0] accumulator_save_o,
  output logic [7:0] core_status_save_o,
  output logic [7:0] indirect_select_save_o,
  output logic restore_o
);

  logic [7:0] primary_flags;
  logic [7:0] secondary_status;
  logic [7:0] primary_irq_mask;
  logic [7:0] secondary_irq_mask;
  logic [7:0] p5_meta, p5_sync, p5_ref;
  logic ext_meta, ext_sync, ext_filt, ext_filt_prev, ext_level_prev;
  logic [3:0] ext_stable_cnt;
  logic [9:0] pending;

  // Pending order is priority order, index 0 highest
  function automatic logic [9:0] prio_vector(input logic [9:0] p);
    logic [9:0] v;
    v = VEC_AUX_C;
    if (p[0]) v = VEC_EXTERNAL;
    else if (p[1]) v = VEC_INPUT_CHANGE;
    else if (p[2]) v = VEC_MAIN_TIMER;
    else if (p[3]) v = VEC_CONV_DONE;
    else if (p[4]) v = VEC_COMPARATOR;
    else if (p[5]) v = VEC_HIGH_PULSE;
    else if (p[6]) v = VEC_LOW_PULSE;
    else if (p[7]) v = VEC_AUX_A;
    else if (p[8]) v = VEC_AUX_B;
    return v;
  endfunction

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      p5_meta <= 8'h00;
      p5_sync <= 8'h00;
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
    end else begin
      p5_meta <= port5_pins_i;
      p5_sync <= p5_meta;
      ext_meta <= ext_pin_i;
      ext_sync <= ext_meta;
    end
  end

  // Reference for change detection is refreshed on every port read
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      p5_ref <= 8'h00;
    end else if (port5_read_i) begin
      p5_ref <= p5_sync;
    end
  end
  logic input_change;
  assign input_change = (p5_sync != p5_ref);

  // Glitch filter: level accepted only after staying put, except in low-frequency crystal mode where it passes straight through
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ext_filt <= 1'b0;
      ext_stable_cnt <= 4'h0;
      ext_level_prev <= 1'b0;
      ext_filt_prev <= 1'b0;
    end else begin
      ext_level_prev <= ext_sync;
      ext_filt_prev <= ext_filt;
      if (low_freq_crystal_mode_i) begin
        ext_filt <= ext_sync;
        ext_stable_cnt <= 4'h0;
      end else if (ext_sync != ext_level_prev || ext_sync == ext_filt) begin
        ext_stable_cnt <= 4'h0;
      end else if (ext_stable_cnt == 4'(FILTER_CYCLES - 2)) begin
        ext_filt <= ext_sync;
        ext_stable_cnt <= 4'h0;
      end else begin
        ext_stable_cnt <= ext_stable_cnt + 4'h1;
      end
    end
  end

  logic ext_event;
  // High select takes rising edges, low takes falling
  assign ext_event = ext_edge_select_i ? (ext_filt & ~ext_filt_prev) : (~ext_filt & ext_filt_prev);

  logic [7:0] primary_set;
  always_comb begin
    primary_set = 8'h00;
    primary_set[BIT_MAIN_TIMER] = main_timer_ovf_i;
    primary_set[BIT_INPUT_CHANGE] = input_change & primary_irq_mask[BIT_INPUT_CHANGE];
    primary_set[BIT_EXTERNAL] = ext_event;
    primary_set[BIT_AUX_A] = aux_timer_a_ovf_i;
    primary_set[BIT_AUX_B] = aux_timer_b_ovf_i;
    primary_set[BIT_AUX_C] = aux_timer_c_ovf_i;
    primary_set[BIT_HIGH_PULSE] = high_pulse_underflow_i;
    primary_set[BIT_LOW_PULSE] = low_pulse_underflow_i;
  end

  logic wr_primary, wr_secondary;
  assign wr_primary = reg_wr_i && reg_addr_i == ADDR_PRIMARY_IRQ_STATUS;
  assign wr_secondary = reg_wr_i && reg_addr_i == ADDR_SECONDARY_IRQ_STATUS;

  // A new event wins over a software clear in the same cycle
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      primary_flags <= PRIMARY_STATUS_RST;
    end else if (wr_primary) begin
      primary_flags <= reg_wdata_i | primary_set;
    end else begin
      primary_flags <= primary_flags | primary_set;
    end
  end

  logic [7:0] secondary_set;
  always_comb begin
    secondary_set = 8'h00;
    secondary_set[BIT_CONV_DONE] = conv_done_i;
    secondary_set[BIT_COMPARATOR] = comparator_change_i;
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      secondary_status <= SECONDARY_STATUS_RST;
    end else if (wr_secondary) begin
      secondary_status <= (reg_wdata_i & SECONDARY_RW_MASK) | secondary_set;
    end else begin
      secondary_status <= secondary_status | secondary_set;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      primary_irq_mask <= PRIMARY_MASK_RST;
      secondary_irq_mask <= SECONDARY_MASK_RST;
    end else if (ioc_wr_i) begin
      if (reg_addr_i == IOC_PRIMARY_IRQ_MASK) begin
        primary_irq_mask <= reg_wdata_i;
      end
      if (reg_addr_i == IOC_SECONDARY_IRQ_MASK) begin
        secondary_irq_mask <= reg_wdata_i & SECONDARY_RW_MASK;
      end
    end
  end

  // Reads of the primary register see only unmasked flags
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        ADDR_PRIMARY_IRQ_STATUS: reg_rdata_o <= primary_flags & primary_irq_mask;
        ADDR_SECONDARY_IRQ_STATUS: reg_rdata_o <= secondary_status;
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  logic [7:0] primary_pend;
  logic [7:0] secondary_pend;
  assign primary_pend = primary_flags & primary_irq_mask;
  assign secondary_pend = secondary_status & secondary_irq_mask;
  assign pending = {primary_pend[BIT_AUX_C], primary_pend[BIT_AUX_B], primary_pend[BIT_AUX_A],
                    primary_pend[BIT_LOW_PULSE], primary_pend[BIT_HIGH_PULSE],
                    secondary_pend[BIT_COMPARATOR], secondary_pend[BIT_CONV_DONE],
                    primary_pend[BIT_MAIN_TIMER], primary_pend[BIT_INPUT_CHANGE],
                    primary_pend[BIT_EXTERNAL]};

  // Ack clears, then enable instructions set, then disable clears
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      global_irq_en_o <= 1'b0;
    end else if (irq_ack_i && irq_req_o) begin
      global_irq_en_o <= 1'b0;
    end else if (global_irq_on_instr_i || return_from_irq_instr_i) begin
      global_irq_en_o <= 1'b1;
    end else if (global_irq_off_instr_i) begin
      global_irq_en_o <= 1'b0;
    end
  end

  // Vector is held registered alongside the request
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_req_o <= 1'b0;
      irq_vector_o <= VEC_EXTERNAL;
    end else begin
      irq_req_o <= global_irq_en_o && (|pending) && !(irq_ack_i && irq_req_o) && !sleeping_o;
      irq_vector_o <= prio_vector(pending);
    end
  end

  logic wake_cause;
  assign wake_cause = (input_change && primary_irq_mask[BIT_INPUT_CHANGE] &&
                       secondary_status[BIT_INPUT_CHANGE_WAKE]) ||
                      (conv_done_i && secondary_status[BIT_CONV_WAKE]) ||
                      (comparator_change_i && secondary_status[BIT_COMPARATOR_WAKE]);

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sleeping_o <= 1'b0;
      wake_o <= 1'b0;
    end else begin
      wake_o <= sleeping_o && wake_cause;
      if (sleeping_o && wake_cause) begin
        sleeping_o <= 1'b0;
      end else if (sleep_instr_i) begin
        sleeping_o <= 1'b1;
      end
    end
  end

  // Only one level of shadow; nested entry loses the outer context
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      accumulator_save_o <= 8'h00;
      core_status_save_o <= 8'h00;
      indirect_select_save_o <= 8'h00;
    end else if (irq_ack_i && irq_req_o) begin
      accumulator_save_o <= accumulator_i;
      core_status_save_o <= core_status_reg_i;
      indirect_select_save_o <= indirect_select_reg_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      restore_o <= 1'b0;
    end else begin
      restore_o <= return_from_irq_instr_i;
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);

  AST_TAKE_CLEARS_GIE: assert property (irq_ack_i && irq_req_o |=> !global_irq_en_o && !irq_req_o)
    else $error("global enable not cleared on vector take");
  AST_RETURN_FROM_IRQ_INSTR_SETS_GIE: assert property (return_from_irq_instr_i && !irq_ack_i |=> global_irq_en_o ##0 restore_o)
    else $error("return did not set enable and restore");
  AST_DISABLE_CLEARS: assert property (global_irq_off_instr_i && !global_irq_on_instr_i &&
                                       !return_from_irq_instr_i |=> !global_irq_en_o)
    else $error("disable instruction ignored");
  AST_READ_ANDED: assert property (reg_rd_i && reg_addr_i == ADDR_PRIMARY_IRQ_STATUS |=>
                                   reg_rdata_o == ($past(primary_flags) & $past(primary_irq_mask)))
    else $error("primary read not masked");
  AST_TIMER_FLAG_SETS: assert property (main_timer_ovf_i |=> primary_flags[BIT_MAIN_TIMER] ##1
                                        (primary_flags[BIT_MAIN_TIMER] || $past(wr_primary)))
    else $error("timer flag not set or not sticky");
  AST_EXT_FIRST: assert property (pending[0] && global_irq_en_o && !sleeping_o && !irq_ack_i |=>
                                  irq_req_o && irq_vector_o == VEC_EXTERNAL)
    else $error("external source not given priority");
  AST_CONV_VECTOR: assert property (pending[3:0] == 4'h8 && global_irq_en_o && !sleeping_o && !irq_ack_i |=>
                                    irq_vector_o == VEC_CONV_DONE)
    else $error("conversion vector wrong");
  AST_MASKED_NO_REQ: assert property (pending == 10'h000 |=> !irq_req_o)
    else $error("request without unmasked flag");
  AST_SHADOW_SAVE: assert property (irq_ack_i && irq_req_o |=> accumulator_save_o == $past(accumulator_i) &&
                                    core_status_save_o == $past(core_status_reg_i))
    else $error("context not saved on entry");
  AST_FILTER_HOLD: assert property (!low_freq_crystal_mode_i && $changed(ext_sync) |=> $stable(ext_filt) [*2])
    else $error("filter passed a short pulse");
  AST_CONV_WAKE: assert property (sleeping_o && conv_done_i && secondary_status[BIT_CONV_WAKE] |=>
                                  !sleeping_o && wake_o)
    else $error("conversion did not wake core");

  COV_EXT_TAKEN: cover property (irq_req_o && irq_ack_i && irq_vector_o == VEC_EXTERNAL);
  COV_WAKE: cover property (wake_o);
  COV_RETURN_FROM_IRQ_INSTR: cover property (irq_ack_i && irq_req_o ##[1:50] return_from_irq_instr_i);
  COV_AUX_C: cover property (irq_req_o && irq_vector_o == VEC_AUX_C);

endmodule

// File: vic_core_model.sv
`timescale 1ns/1ps
module vic_core_model
  import vic_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  // Vector handshake
  input wire logic irq_req_i,
  input wire logic [9:0] irq_vector_i,
  input wire logic [3:0] ack_delay_i,
  output logic irq_ack_o,
  // Observation
  output logic [9:0] taken_vector_o,
  output logic [7:0] take_count_o
);
  int waited;
  // Request and vector are registered, so the falling edge sees them settled
  initial begin
    irq_ack_o = 1'b0;
    taken_vector_o = 10'h000;
    take_count_o = 8'h00;
    waited = 0;
    forever begin
      @(negedge ref_clk_i);
      if (sys_rst_i || !irq_req_i) begin
        waited = 0;
      end else if (waited < int'(ack_delay_i)) begin
        waited++;
      end else begin
        irq_ack_o = 1'b1;
        taken_vector_o = irq_vector_i;
        take_count_o = take_count_o + 8'h01;
        @(negedge ref_clk_i);
        irq_ack_o = 1'b0;
        // Let the request drop before looking again
        waited = 0;
        @(negedge ref_clk_i);
      end
    end
  end
endmodule

// File: vic_top_test.sv
`timescale 1ns/1ps
module vic_top_test import vic_pkg::*;;
  logic ref_clk_i, sys_rst_i, ext, esel, low_freq_crystal_mode, rd, wr, iwr, p5rd, ack, req, gie, slp, wake, rest;
  logic [7:0] ev, port5, wdata, rdata, acc, st, sel, acc_s, st_s, sel_s, takes;
  logic [5:0] addr;
  logic [3:0] ins, lat;
  logic [9:0] vec, seen;
  int n_fail = 0;
  int checks_done = 0;

  vic_top i_dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .main_timer_ovf_i(ev[0]), .aux_timer_a_ovf_i(ev[1]), .aux_timer_b_ovf_i(ev[2]), .aux_timer_c_ovf_i(ev[3]),
    .high_pulse_underflow_i(ev[4]), .low_pulse_underflow_i(ev[5]), .conv_done_i(ev[6]),
    .comparator_change_i(ev[7]), .port5_pins_i(port5), .ext_pin_i(ext), .ext_edge_select_i(esel),
    .low_freq_crystal_mode_i(low_freq_crystal_mode), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .ioc_wr_i(iwr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .port5_read_i(p5rd), .global_irq_on_instr_i(ins[0]),
    .global_irq_off_instr_i(ins[1]), .return_from_irq_instr_i(ins[2]), .sleep_instr_i(ins[3]),
    .irq_req_o(req), .irq_vector_o(vec), .irq_ack_i(ack), .global_irq_en_o(gie), .sleeping_o(slp),
    .wake_o(wake), .accumulator_i(acc), .core_status_reg_i(st), .indirect_select_reg_i(sel),
    .accumulator_save_o(acc_s), .core_status_save_o(st_s), .indirect_select_save_o(sel_s), .restore_o(rest));
  vic_core_model i_core (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .irq_req_i(req), .irq_vector_i(vec),
    .ack_delay_i(lat), .irq_ack_o(ack), .taken_vector_o(seen), .take_count_o(takes));

  initial begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t byte got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_vec(input logic [9:0] got, input logic [9:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t vector got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %0t flag got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d, input logic ioc);
    @(negedge ref_clk_i);
    addr = a;
    wdata = d;
    wr = !ioc;
    iwr = ioc;
    @(negedge ref_clk_i);
    wr = 1'b0;
    iwr = 1'b0;
  endtask
  task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
    @(negedge ref_clk_i);
    addr = a;
    rd = 1'b1;
    @(negedge ref_clk_i);
    rd = 1'b0;
    @(negedge ref_clk_i);
    d = rdata;
  endtask
  task automatic pulse_ins(input int i);
    @(negedge ref_clk_i);
    ins[i] = 1'b1;
    @(negedge ref_clk_i);
    ins = 4'h0;
  endtask
  task automatic pulse_ev(input logic [7:0] m);
    @(negedge ref_clk_i);
    ev = m;
    @(negedge ref_clk_i);
    ev = 8'h00;
  endtask
  task automatic read_port5();
    @(negedge ref_clk_i);
    p5rd = 1'b1;
    @(negedge ref_clk_i);
    p5rd = 1'b0;
  endtask
  task automatic set_core(input logic [7:0] x);
    acc = 8'h10 + x;
    st = 8'h20 + x;
    sel = 8'h40 + x;
  endtask
  task automatic clear_return();
    wr_reg(ADDR_PRIMARY_IRQ_STATUS, 8'h00, 1'b0);
    pulse_ins(2);
  endtask
  // Bounded so a missing request ends as a mismatch, not a hang
  task automatic wait_take(input logic [9:0] exp);
    logic [7:0] t0;
    int k;
    t0 = takes;
    k = 0;
    while (takes === t0 && k < 200) begin
      @(posedge ref_clk_i);
      k++;
    end
    @(negedge ref_clk_i);
    @(negedge ref_clk_i);
    chk_vec(seen, exp);
    chk_bit(gie, 1'b0);
    chk_bit(req, 1'b0);
  endtask
  task automatic wait_wake();
    int k;
    k = 0;
    while (wake !== 1'b1 && k < 50) begin
      @(negedge ref_clk_i);
      k++;
    end
    chk_bit(wake, 1'b1);
    @(negedge ref_clk_i);
    chk_bit(slp, 1'b0);
  endtask

  task automatic t_reset();
    logic [7:0] d;
    rd_reg(ADDR_SECONDARY_IRQ_STATUS, d);
    chk_reg(d, SECONDARY_STATUS_RST);
    rd_reg(ADDR_PRIMARY_IRQ_STATUS, d);
    chk_reg(d, PRIMARY_STATUS_RST);
    wr_reg(ADDR_SECONDARY_IRQ_STATUS, 8'hff, 1'b0);
    rd_reg(ADDR_SECONDARY_IRQ_STATUS, d);
    chk_reg(d, 8'h3e);
    wr_reg(ADDR_SECONDARY_IRQ_STATUS, 8'h00, 1'b0);
    rd_reg(6'h05, d);
    chk_reg(d, 8'h00);
    $display("reset test done");
  endtask
  task automatic t_mask();
    logic [7:0] d;
    pulse_ev(8'h03);
    rd_reg(ADDR_PRIMARY_IRQ_STATUS, d);
    chk_reg(d, 8'h00);
    wr_reg(IOC_PRIMARY_IRQ_MASK, 8'h01, 1'b1);
    rd_reg(ADDR_PRIMARY_IRQ_STATUS, d);
    chk_reg(d, 8'h01);
    chk_bit(req, 1'b0);
    wr_reg(ADDR_PRIMARY_IRQ_STATUS, 8'h00, 1'b0);
    $display("mask test done");
  endtask
  task automatic t_vectors();
    logic [9:0] exp_vec [8];
    logic [15:0] clr [8];
    logic [7:0] pf, sf, b;
    exp_vec = '{VEC_MAIN_TIMER, VEC_CONV_DONE, VEC_COMPARATOR, VEC_HIGH_PULSE,
      VEC_LOW_PULSE, VEC_AUX_A, VEC_AUX_B, VEC_AUX_C};
    clr = '{16'h0001, 16'h2000, 16'h1000, 16'h0040, 16'h0080, 16'h0008, 16'h0010, 16'h0020};
    pf = 8'hf9;
    sf = 8'h30;
    wr_reg(IOC_PRIMARY_IRQ_MASK, pf, 1'b1);
    wr_reg(IOC_SECONDARY_IRQ_MASK, sf, 1'b1);
    pulse_ev(8'hff);
    set_core(8'h00);
    pulse_ins(0);
    for (int i = 0; i < 8; i++) begin
      b = 8'(i);
      lat = b[0] ? 4'h5 : 4'h0;
      wait_take(exp_vec[i]);
      chk_reg(acc_s, 8'h10 + b);
      chk_reg(st_s, 8'h20 + b);
      chk_reg(sel_s, 8'h40 + b);
      pf = pf & ~clr[i][7:0];
      sf = sf & ~clr[i][15:8];
      wr_reg(ADDR_PRIMARY_IRQ_STATUS, pf, 1'b0);
      wr_reg(ADDR_SECONDARY_IRQ_STATUS, sf, 1'b0);
      set_core(b + 8'h01);
      pulse_ins(2);
      chk_bit(rest, 1'b1);
      chk_bit(gie, 1'b1);
    end
    $display("vector test done");
  endtask
  task automatic t_ext();
    logic [7:0] d;
    wr_reg(IOC_PRIMARY_IRQ_MASK, 8'h04, 1'b1);
    ext = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    ext = 1'b0;
    repeat (20) @(negedge ref_clk_i);
    rd_reg(ADDR_PRIMARY_IRQ_STATUS, d);
    chk_reg(d, 8'h00);
    ext = 1'b1;
    wait_take(VEC_EXTERNAL);
    clear_return();
    esel = 1'b0;
    ext = 1'b0;
    wait_take(VEC_EXTERNAL);
    clear_return();
    esel = 1'b1;
    low_freq_crystal_mode = 1'b1;
    ext = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    ext = 1'b0;
    wait_take(VEC_EXTERNAL);
    clear_return();
    low_freq_crystal_mode = 1'b0;
    $display("external pin test done");
  endtask
  task automatic t_sleep();
    logic [7:0] t0, d;
    read_port5();
    wr_reg(IOC_PRIMARY_IRQ_MASK, 8'h02, 1'b1);
    wr_reg(ADDR_SECONDARY_IRQ_STATUS, 8'h02, 1'b0);
    pulse_ins(3);
    @(negedge ref_clk_i);
    chk_bit(slp, 1'b1);
    port5 = 8'h01;
    wait_wake();
    wait_take(VEC_INPUT_CHANGE);
    read_port5();
    clear_return();
    pulse_ins(1);
    chk_bit(gie, 1'b0);
    wr_reg(ADDR_SECONDARY_IRQ_STATUS, 8'h08, 1'b0);
    pulse_ins(3);
    t0 = takes;
    pulse_ev(8'h40);
    wait_wake();
    repeat (10) @(negedge ref_clk_i);
    chk_reg(takes, t0);
    rd_reg(ADDR_SECONDARY_IRQ_STATUS, d);
    chk_reg(d, 8'h28);
    pulse_ins(0);
    wait_take(VEC_CONV_DONE);
    wr_reg(ADDR_SECONDARY_IRQ_STATUS, 8'h00, 1'b0);
    pulse_ins(2);
    $display("sleep test done");
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk_i);
    n_fail++;
    $display("Error %0t watchdog expired", $time);
    results();
  end
  initial begin
    {ext, low_freq_crystal_mode, rd, wr, iwr, p5rd} = 6'h00;
    esel = 1'b1;
    {ev, port5, wdata, acc, st, sel} = 48'h0;
    addr = 6'h00;
    ins = 4'h0;
    lat = 4'h0;
    sys_rst_i = 1'b1;
    repeat (12) @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    t_reset();
    t_mask();
    t_vectors();
    t_ext();
    t_sleep();
    results();
  end
endmodule
